// ### pkg/hdltx_defines.svh
`ifndef HDLTX_DEFINES_SVH
`define HDLTX_DEFINES_SVH

`define HDLTX_FLAG          8'h7e
`define HDLTX_ABORT         8'h7f
`define HDLTX_MARK_IDLE     8'hff
`define HDLTX_CRC_PRESET    16'hffff
`define HDLTX_CRC_POLY_REV  16'h8408
`define HDLTX_FIFO_DEPTH    128
`define HDLTX_STUFF_RUN     3'h5
`define HDLTX_LAST_BIT      3'h7
`define HDLTX_FDL_RATE_HZ   4000
`define HDLTX_SA_BITS       5

`endif

// ### pkg/hdltx_pkg.sv
package hdltx_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DATA,
      ST_CRC_LO,
      ST_CRC_HI
   } hdltx_state_t;

   typedef enum logic [1:0] {
      K_FLAG,
      K_DATA,
      K_CRC,
      K_ABORT
   } hdltx_kind_t;

endpackage

// ### logic/hdltx_fifo.sv
`timescale 1ns/1ns
module hdltx_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 128,
   parameter int CW    = $clog2(DEPTH) + 1
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_push,
   input  wire logic [W-1:0]  i_data,
   input  wire logic          i_pop,
   output logic      [W-1:0]  o_data,
   output logic               o_valid,
   output logic               o_full,
   output logic      [CW-1:0] o_count
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [CW-1:0] count_ff;
   logic          do_push;
   logic          do_pop;

   assign o_full  = (count_ff == FULL_CNT);
   assign o_valid = (count_ff != '0);
   assign o_count = count_ff;
   assign o_data  = mem[rd_ptr_ff];
   assign do_push = i_push && !o_full;
   assign do_pop  = i_pop && o_valid;

   always_ff @(posedge i_clk) begin
      if (do_push) begin
         mem[wr_ptr_ff] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
         end
         if (do_pop) begin
            rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
         end
         if (do_push && !do_pop) begin
            count_ff <= CW'(count_ff + 1'b1);
         end else if (do_pop && !do_push) begin
            count_ff <= CW'(count_ff - 1'b1);
         end
      end
   end
endmodule

// ### logic/hdltx_crc.sv
`timescale 1ns/1ns
`include "hdltx_defines.svh"
module hdltx_crc (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_init,
   input  wire logic        i_en,
   input  wire logic        i_bit,
   output logic      [15:0] o_crc,
   output logic      [15:0] o_crc_nxt
);
   logic [15:0] crc_ff;
   logic [15:0] step;

   // reflected form of x^16+x^12+x^5+1, data taken lsb first
   assign step      = (crc_ff >> 1) ^ ((crc_ff[0] ^ i_bit) ? `HDLTX_CRC_POLY_REV : 16'h0000);
   assign o_crc     = crc_ff;
   assign o_crc_nxt = i_en ? step : crc_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         crc_ff <= `HDLTX_CRC_PRESET;
      end else if (i_init) begin
         crc_ff <= `HDLTX_CRC_PRESET;
      end else if (i_en) begin
         crc_ff <= step;
      end
   end
endmodule

// ### logic/hdltx_hdlc_tx_engine.sv
// Overview of operation
// - serial output feeds the 4 kHz T1 facility data link or E1 Sa-bits
// - enabled with no packet ready, send back-to-back 01111110 flags
// - bytes written while the FIFO is not full are queued and, unless flushed after an abort, shifted out serially
// - after last byte send optional CRC then a flag, then idle flags
// - default mode starts a packet automatically once it is fully queued
// - default mode also starts when the FIFO becomes full
// - FIFO holds 128 bytes; default-mode underrun only for longer packets
// - threshold mode sends from upper threshold until below it, packet done
// - flag an event when occupancy falls below the lower threshold
// - event outputs for underflow, below lower threshold, full and overrun
// - insert a zero after five consecutive ones in data or check word
// - abort control bit forces continuous abort characters
// - FIFO empty mid-packet sends abort and raises underrun indication
// - each E1 Sa-bit can be selected to carry the HDLC bit
// - on T1 link, yellow alarm beats bit codes which beat HDLC
`timescale 1ns/1ns
`include "hdltx_defines.svh"
module hdltx_hdlc_tx_engine #(
   parameter int DEPTH = `HDLTX_FIFO_DEPTH,
   parameter int CW    = $clog2(DEPTH) + 1,
   parameter int NSA   = `HDLTX_SA_BITS
) (
   input  wire logic           i_clk,
   input  wire logic           i_reset_n,
   input  wire logic           i_enable,
   input  wire logic           i_crc_en,
   input  wire logic           i_thresh_mode,
   input  wire logic           i_abort,
   input  wire logic [CW-1:0]  i_upper_thr,
   input  wire logic [CW-1:0]  i_lower_thr,
   input  wire logic           i_wr_strobe,
   input  wire logic [7:0]     i_wr_data,
   input  wire logic           i_wr_eop,
   input  wire logic           i_bit_req,
   input  wire logic           i_yellow_active,
   input  wire logic           i_yellow_bit,
   input  wire logic           i_boc_active,
   input  wire logic           i_boc_bit,
   input  wire logic [NSA-1:0] i_sa_sel,
   input  wire logic [NSA-1:0] i_sa_alt,
   output logic                o_fdl_bit,
   output logic      [NSA-1:0] o_sa_bits,
   output logic                o_hdlc_bit,
   output logic                o_underrun_irq,
   output logic                o_lower_irq,
   output logic                o_full_irq,
   output logic                o_overrun_irq,
   output logic      [CW-1:0]  o_fifo_count
);
   logic [1:0]             rst_sync_ff;
   logic                   rst_n;
   hdltx_pkg::hdltx_state_t state_ff;
   hdltx_pkg::hdltx_state_t nxt_state;
   hdltx_pkg::hdltx_kind_t  kind_ff;
   hdltx_pkg::hdltx_kind_t  nxt_kind;
   logic [7:0]             sh_ff;
   logic [7:0]             nxt_byte;
   logic [2:0]             cnt_ff;
   logic [2:0]             ones_ff;
   logic                   cur_eop_ff;
   logic                   nxt_eop;
   logic                   flush_ff;
   logic                   thr_go_ff;
   logic [CW-1:0]          pkt_cnt_ff;
   logic [CW-1:0]          cnt_prev_ff;
   logic                   full_prev_ff;
   logic                   ld_pop;
   logic                   crc_init;
   logic                   udr_ev;
   logic                   set_flush;
   logic                   flush_pop;
   logic                   f_pop;
   logic                   f_push;
   logic [8:0]             f_data;
   logic                   f_valid;
   logic                   f_full;
   logic [CW-1:0]          f_count;
   logic [15:0]            crc;
   logic [15:0]            crc_nxt;
   logic                   stuffable;
   logic                   stuff_now;
   logic                   ser_bit;
   logic                   advance;
   logic                   byte_end;
   logic                   start_ok;
   logic                   pkt_inc;
   logic                   pkt_dec;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   assign f_push = i_wr_strobe && !f_full;
   hdltx_fifo #(.W(9), .DEPTH(DEPTH), .CW(CW)) u_fifo (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_push  (f_push),
      .i_data  ({i_wr_eop, i_wr_data}),
      .i_pop   (f_pop),
      .o_data  (f_data),
      .o_valid (f_valid),
      .o_full  (f_full),
      .o_count (f_count)
   );

   assign stuffable = (kind_ff == hdltx_pkg::K_DATA) || (kind_ff == hdltx_pkg::K_CRC);
   assign stuff_now = (ones_ff == `HDLTX_STUFF_RUN);
   assign ser_bit   = stuff_now ? 1'b0 : sh_ff[0];
   assign advance   = i_bit_req && !stuff_now;
   assign byte_end  = advance && (cnt_ff == `HDLTX_LAST_BIT);

   hdltx_crc u_crc (
      .i_clk     (i_clk),
      .i_rst_n   (rst_n),
      .i_init    (byte_end && crc_init),
      .i_en      (advance && (kind_ff == hdltx_pkg::K_DATA)),
      .i_bit     (sh_ff[0]),
      .o_crc     (crc),
      .o_crc_nxt (crc_nxt)
   );

   // default mode waits for a whole packet or a full FIFO
   assign start_ok = i_thresh_mode ? thr_go_ff : ((pkt_cnt_ff != '0) || f_full);

   always_comb begin
      nxt_state = state_ff;
      nxt_byte  = `HDLTX_FLAG;
      nxt_kind  = hdltx_pkg::K_FLAG;
      nxt_eop   = cur_eop_ff;
      ld_pop    = 1'b0;
      crc_init  = 1'b0;
      udr_ev    = 1'b0;
      set_flush = 1'b0;
      if (!i_enable) begin
         nxt_state = hdltx_pkg::ST_IDLE;
         nxt_byte  = `HDLTX_MARK_IDLE;
      end else if (i_abort) begin
         nxt_state = hdltx_pkg::ST_IDLE;
         nxt_byte  = `HDLTX_ABORT;
         nxt_kind  = hdltx_pkg::K_ABORT;
         set_flush = (state_ff == hdltx_pkg::ST_DATA) && !cur_eop_ff;
      end else begin
         case (state_ff)
            hdltx_pkg::ST_DATA: begin
               if (cur_eop_ff) begin
                  if (i_crc_en) begin
                     nxt_state = hdltx_pkg::ST_CRC_LO;
                     nxt_byte  = ~crc_nxt[7:0];
                     nxt_kind  = hdltx_pkg::K_CRC;
                  end else begin
                     nxt_state = hdltx_pkg::ST_IDLE;
                  end
               end else if (f_valid) begin
                  ld_pop   = 1'b1;
                  nxt_byte = f_data[7:0];
                  nxt_eop  = f_data[8];
                  nxt_kind = hdltx_pkg::K_DATA;
               end else begin
                  nxt_state = hdltx_pkg::ST_IDLE;
                  nxt_byte  = `HDLTX_ABORT;
                  nxt_kind  = hdltx_pkg::K_ABORT;
                  udr_ev    = 1'b1;
                  set_flush = 1'b1;
               end
            end
            hdltx_pkg::ST_CRC_LO: begin
               nxt_state = hdltx_pkg::ST_CRC_HI;
               nxt_byte  = ~crc[15:8];
               nxt_kind  = hdltx_pkg::K_CRC;
            end
            hdltx_pkg::ST_CRC_HI: begin
               nxt_state = hdltx_pkg::ST_IDLE;
            end
            default: begin
               if (start_ok && f_valid && !flush_ff) begin
                  nxt_state = hdltx_pkg::ST_DATA;
                  ld_pop    = 1'b1;
                  crc_init  = 1'b1;
                  nxt_byte  = f_data[7:0];
                  nxt_eop   = f_data[8];
                  nxt_kind  = hdltx_pkg::K_DATA;
               end else begin
                  nxt_state = hdltx_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // the remainder of an aborted packet is discarded up to its end marker
   assign flush_pop = flush_ff && f_valid && (state_ff != hdltx_pkg::ST_DATA);
   assign f_pop     = (byte_end && ld_pop) || flush_pop;
   assign pkt_inc   = f_push && i_wr_eop;
   assign pkt_dec   = f_pop && f_data[8];

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= hdltx_pkg::ST_IDLE;
         kind_ff    <= hdltx_pkg::K_FLAG;
         sh_ff      <= `HDLTX_FLAG;
         cnt_ff     <= 3'h0;
         cur_eop_ff <= 1'b0;
      end else if (byte_end) begin
         state_ff   <= nxt_state;
         kind_ff    <= nxt_kind;
         sh_ff      <= nxt_byte;
         cnt_ff     <= 3'h0;
         cur_eop_ff <= nxt_eop;
      end else if (advance) begin
         sh_ff  <= {1'b1, sh_ff[7:1]};
         cnt_ff <= 3'(cnt_ff + 1'b1);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_ff <= 3'h0;
      end else if (i_bit_req) begin
         if (stuff_now || !stuffable || !sh_ff[0]) begin
            ones_ff <= 3'h0;
         end else begin
            ones_ff <= 3'(ones_ff + 1'b1);
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         flush_ff <= 1'b0;
      end else if (byte_end && set_flush) begin
         flush_ff <= 1'b1;
      end else if (flush_pop && f_data[8]) begin
         flush_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_go_ff <= 1'b0;
      end else if (f_count >= i_upper_thr) begin
         thr_go_ff <= 1'b1;
      end else if (state_ff == hdltx_pkg::ST_IDLE) begin
         thr_go_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pkt_cnt_ff <= '0;
      end else if (pkt_inc && !pkt_dec) begin
         pkt_cnt_ff <= CW'(pkt_cnt_ff + 1'b1);
      end else if (pkt_dec && !pkt_inc) begin
         pkt_cnt_ff <= CW'(pkt_cnt_ff - 1'b1);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_hdlc_bit <= 1'b1;
         o_fdl_bit  <= 1'b1;
      end else if (i_bit_req) begin
         o_hdlc_bit <= ser_bit;
         if (i_yellow_active) begin
            o_fdl_bit <= i_yellow_bit;
         end else if (i_boc_active) begin
            o_fdl_bit <= i_boc_bit;
         end else begin
            o_fdl_bit <= ser_bit;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NSA; gi++) begin : g_sa
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               o_sa_bits[gi] <= 1'b1;
            end else if (i_bit_req) begin
               o_sa_bits[gi] <= i_sa_sel[gi] ? ser_bit : i_sa_alt[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_prev_ff    <= '0;
         full_prev_ff   <= 1'b0;
         o_underrun_irq <= 1'b0;
         o_lower_irq    <= 1'b0;
         o_full_irq     <= 1'b0;
         o_overrun_irq  <= 1'b0;
         o_fifo_count   <= '0;
      end else begin
         cnt_prev_ff    <= f_count;
         full_prev_ff   <= f_full;
         o_underrun_irq <= byte_end && udr_ev;
         o_lower_irq    <= (f_count < i_lower_thr) && (cnt_prev_ff >= i_lower_thr);
         o_full_irq     <= f_full && !full_prev_ff;
         o_overrun_irq  <= i_wr_strobe && f_full;
         o_fifo_count   <= f_count;
      end
   end
endmodule

// ### verification/hdltx_framer_model.sv
`timescale 1ns/1ns
module hdltx_framer_model (
   input  wire logic       i_clk,
   input  wire logic [3:0] i_gap,
   input  wire logic       i_line,
   output logic            o_bit_req,
   output logic            o_got,
   output logic            o_got_bit
);
   logic [3:0] cnt_ff;
   // gap of f holds the link still, else one strobe every gap+1 cycles
   always_ff @(posedge i_clk) begin
      o_got     <= o_bit_req;
      o_got_bit <= i_line;
      if (i_gap == 4'hf) begin
         o_bit_req <= 1'b0;
         cnt_ff    <= 4'h0;
      end else if (cnt_ff == 4'h0) begin
         o_bit_req <= 1'b1;
         cnt_ff    <= i_gap;
      end else begin
         o_bit_req <= 1'b0;
         cnt_ff    <= cnt_ff - 4'h1;
      end
   end
endmodule

// ### verification/hdltx_checker_assertions.sv
`timescale 1ns/1ns
module hdltx_checker #(
   parameter int DEPTH = 128,
   parameter int CW    = 8,
   parameter int NSA   = 5
) (
   input wire logic           i_clk,
   input wire logic           i_reset_n,
   input wire logic [CW-1:0]  i_lower_thr,
   input wire logic           i_bit_req,
   input wire logic           i_yellow_active,
   input wire logic           i_yellow_bit,
   input wire logic           i_boc_active,
   input wire logic           i_boc_bit,
   input wire logic [NSA-1:0] i_sa_sel,
   input wire logic [NSA-1:0] i_sa_alt,
   input wire logic           o_fdl_bit,
   input wire logic [NSA-1:0] o_sa_bits,
   input wire logic           o_hdlc_bit,
   input wire logic           o_underrun_irq,
   input wire logic           o_lower_irq,
   input wire logic           o_full_irq,
   input wire logic           o_overrun_irq,
   input wire logic [CW-1:0]  o_fifo_count
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_yel;
      i_bit_req && i_yellow_active;
   endsequence
   sequence s_boc;
      i_bit_req && !i_yellow_active && i_boc_active;
   endsequence
   a_yellow_wins: assert property (s_yel |=> o_fdl_bit == $past(i_yellow_bit))
      else $error("fdl bit ignores yellow");
   a_boc_next: assert property (s_boc |=> o_fdl_bit == $past(i_boc_bit))
      else $error("fdl bit ignores bit code");
   a_sa_route: assert property (i_bit_req |=> o_sa_bits ==
      (($past(i_sa_sel) & {NSA{o_hdlc_bit}}) | (~$past(i_sa_sel) & $past(i_sa_alt))))
      else $error("sa bits misrouted");
   a_bit_hold: assert property (!i_bit_req |=> $stable(o_hdlc_bit) && $stable(o_sa_bits))
      else $error("serial bit moved without request");
   a_full_level: assert property (o_full_irq |-> ##[0:2] o_fifo_count >= DEPTH - 1)
      else $error("full pulse without full fifo");
   a_ovr_full: assert property (o_overrun_irq |-> o_fifo_count >= DEPTH - 1)
      else $error("overrun pulse without full fifo");
   a_low_level: assert property (o_lower_irq |-> ##[0:2] o_fifo_count < i_lower_thr)
      else $error("lower pulse above threshold");
   a_und_pulse: assert property (o_underrun_irq |=> !o_underrun_irq)
      else $error("underrun pulse too long");
   a_cnt_max: assert property (o_fifo_count <= DEPTH)
      else $error("fifo count above depth");
endmodule
bind hdltx_hdlc_tx_engine hdltx_checker #(.DEPTH(DEPTH), .CW(CW), .NSA(NSA)) chk_inst (
   .i_clk, .i_reset_n, .i_lower_thr, .i_bit_req, .i_yellow_active, .i_yellow_bit,
   .i_boc_active, .i_boc_bit, .i_sa_sel, .i_sa_alt, .o_fdl_bit, .o_sa_bits, .o_hdlc_bit,
   .o_underrun_irq, .o_lower_irq, .o_full_irq, .o_overrun_irq, .o_fifo_count);

// ### verification/tb.sv
`timescale 1ns/1ns
module tb;
   typedef struct {int len; logic crc; logic [7:0] b0; logic [7:0] st;} hdltx_row_t;
   logic       i_clk, i_reset_n, i_enable, i_crc_en, i_thresh_mode, i_abort;
   logic       i_wr_strobe, i_wr_eop, i_bit_req, got, gb;
   logic       i_yellow_active, i_yellow_bit, i_boc_active, i_boc_bit;
   logic       o_fdl_bit, o_hdlc_bit, o_underrun_irq, o_lower_irq, o_full_irq, o_overrun_irq;
   logic [7:0] i_upper_thr, i_lower_thr, i_wr_data, o_fifo_count;
   logic [4:0] i_sa_sel, i_sa_alt, o_sa_bits;
   logic [3:0] gap;
   logic [15:0] c;
   logic       bq[$];
   logic [7:0] fr[$], ex[$];
   int         n_fail, checks, nfr, nab, nflag, nund, nfull, novr, nlow, ones, n0;
   hdltx_row_t rows[4] = '{'{1, 0, 8'h00, 8'h00}, '{3, 1, 8'hff, 8'h00},
                           '{5, 1, 8'h7e, 8'h11}, '{2, 0, 8'h7c, 8'h83}};
   hdltx_hdlc_tx_engine hdltx_hdlc_tx_engine_inst (
      .i_clk, .i_reset_n, .i_enable, .i_crc_en, .i_thresh_mode, .i_abort, .i_upper_thr,
      .i_lower_thr, .i_wr_strobe, .i_wr_data, .i_wr_eop, .i_bit_req, .i_yellow_active,
      .i_yellow_bit, .i_boc_active, .i_boc_bit, .i_sa_sel, .i_sa_alt, .o_fdl_bit,
      .o_sa_bits, .o_hdlc_bit, .o_underrun_irq, .o_lower_irq, .o_full_irq,
      .o_overrun_irq, .o_fifo_count);
   hdltx_framer_model hdltx_framer_model_inst (
      .i_clk, .i_gap(gap), .i_line(o_hdlc_bit), .o_bit_req(i_bit_req), .o_got(got),
      .o_got_bit(gb));
   initial begin
      i_clk = 0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      nund += o_underrun_irq;
      nfull += o_full_irq;
      novr += o_overrun_irq;
      nlow += o_lower_irq;
   end
   // deframer: drop stuffed zeros, split on flags, count aborts
   always @(negedge i_clk) if (got === 1'b1) begin
      if (gb === 1'b1) begin
         ones++;
         if (ones == 7) begin
            nab++;
            bq = {};
         end
         bq.push_back(1'b1);
      end else if (ones == 5) begin
         ones = 0;
      end else begin
         if (ones == 6) begin
            nflag++;
            repeat (7) if (bq.size() > 0) void'(bq.pop_back());
            if (bq.size() > 0 && bq.size() % 8 == 0) begin
               fr = {};
               for (int i = 0; i < bq.size(); i++) begin
                  if (i % 8 == 0) fr.push_back(8'h00);
                  fr[i/8][i%8] = bq[i];
               end
               nfr++;
            end
            bq = {};
         end else begin
            bq.push_back(1'b0);
         end
         ones = 0;
      end
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] r;
      r = 16'hffff;
      foreach (q[i]) for (int k = 0; k < 8; k++)
         r = (r[0] ^ q[i][k]) ? (r >> 1) ^ 16'h8408 : r >> 1;
      return r;
   endfunction
   task stop_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] d, input logic e);
      @(posedge i_clk);
      i_wr_strobe <= 1'b1;
      i_wr_data <= d;
      i_wr_eop <= e;
   endtask
   task wr_end;
      @(posedge i_clk);
      i_wr_strobe <= 1'b0;
   endtask
   task waitf(input int n);
      for (int i = 0; i < 40000 && nfr < n; i++) @(posedge i_clk);
      if (nfr < n) begin
         n_fail++;
         $display("FAIL %0t frame timeout", $time);
         stop_test;
      end
   endtask
   initial begin
      i_reset_n = 0; i_enable = 1; i_crc_en = 0; i_thresh_mode = 0; i_abort = 0;
      i_upper_thr = 8'h04; i_lower_thr = 8'h40; i_wr_strobe = 0; i_wr_data = 8'h00;
      i_wr_eop = 0; i_yellow_active = 0; i_yellow_bit = 0; i_boc_active = 0;
      i_boc_bit = 0; i_sa_sel = 5'h15; i_sa_alt = 5'h0a; gap = 4'hf;
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      gap <= 4'h0;
      repeat (64) @(posedge i_clk);
      chk(nflag >= 6, 1);
      foreach (rows[r]) begin
         i_crc_en <= rows[r].crc;
         ex = {};
         for (int k = 0; k < rows[r].len; k++) begin
            ex.push_back(rows[r].b0 + rows[r].st * k);
            wr(ex[k], k == rows[r].len - 1);
         end
         wr_end;
         c = crc16(ex);
         if (rows[r].crc) ex = {ex, ~c[7:0], ~c[15:8]};
         waitf(nfr + 1);
         chk(fr.size(), ex.size());
         foreach (ex[i]) chk(fr[i], ex[i]);
      end
      n0 = nab;
      i_abort <= 1'b1;
      repeat (48) @(posedge i_clk);
      i_abort <= 1'b0;
      chk(nab > n0 + 3, 1);
      i_enable <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         {i_yellow_active, i_boc_active} <= i[1:0];
         {i_yellow_bit, i_boc_bit} <= {i[0], ~i[0]};
         repeat (8) @(posedge i_clk);
         chk(o_fdl_bit, (i == 0) ? o_hdlc_bit : (i[1] ? i[0] : 1'b0));
      end
      chk(o_sa_bits, i_sa_sel | i_sa_alt);
      {i_enable, i_yellow_active, i_boc_active} <= 3'h4;
      repeat (40) @(posedge i_clk);
      i_thresh_mode <= 1'b1;
      n0 = nfr;
      for (int k = 0; k < 3; k++) wr(8'h31 + k, k == 2);
      wr_end;
      repeat (300) @(posedge i_clk);
      chk(nfr, n0);
      for (int k = 0; k < 5; k++) wr(8'h51 + k, k == 4);
      wr_end;
      waitf(n0 + 2);
      chk(fr.size(), 5);
      i_thresh_mode <= 1'b0;
      gap <= 4'hf;
      n0 = nab;
      for (int k = 0; k < 129; k++) wr(k[7:0], 1'b0);
      wr_end;
      gap <= 4'h3;
      for (int i = 0; i < 20000 && nund == 0; i++) @(posedge i_clk);
      // let the abort byte reach the deframer
      repeat (64) @(posedge i_clk);
      chk(nund, 1);
      chk(nab > n0, 1);
      chk(nfull, 1);
      chk(novr, 1);
      chk(nlow, 1);
      n0 = nfr;
      wr(8'h00, 1'b1);
      wr_end;
      repeat (200) @(posedge i_clk);
      chk(o_fifo_count, 0);
      chk(nfr, n0);
      stop_test;
   end
endmodule
